// >>> inc/dac_clk_pkg.sv
// Summary of operation
// - pll off: reference clock drives sample clock
// - pll on: sample clock from multiplier
// - vco ratio is prescale times multiplier
// - sample clock ratio is multiplier alone
// - band codes 0..62 manual, all-ones automatic
// - loop bandwidth code scales filter monotonically
// - auto mode searches band without host help
// - prescale bits 6:5, multiplier bits 4:3
// - lock raises pin and status bit
// - band readback returns auto chosen band
package dac_clk_pkg;
  // =====================================================
  // register map
  localparam logic [4:0] REG_LOCK_STATUS = 5'h00;
  localparam logic [4:0] REG_VCO_BAND    = 5'h08;
  localparam logic [4:0] REG_PLL_CTRL    = 5'h09;
  localparam logic [4:0] REG_LOOP_BW     = 5'h0a;
  localparam int LOCK_BIT   = 1;
  localparam int PLL_EN_BIT = 7;
  localparam int N1_HI      = 6;
  localparam int N1_LO      = 5;
  localparam int N2_HI      = 4;
  localparam int N2_LO      = 3;
  localparam int BIAS_HI    = 2;
  localparam int BAND_HI    = 7;
  localparam int BAND_LO    = 2;
  localparam int DRIVE_HI   = 1;
  localparam int LBW_HI     = 4;
  localparam logic [5:0] BAND_AUTO = 6'h3f;
  localparam logic [5:0] BAND_MAX  = 6'h3e;
  localparam logic [5:0] BAND_MIN  = 6'h00;
  localparam logic [7:0] RST_VCO_BAND = 8'h03;
  localparam logic [7:0] RST_PLL_CTRL = 8'h03;
  localparam logic [4:0] RST_LOOP_BW  = 5'h0f;
  // =====================================================
  // serial frame
  localparam logic [4:0] LAST_INSTR_BIT = 5'h07;
  localparam logic [4:0] LAST_FRAME_BIT = 5'h0f;
  localparam int RW_BIT = 7;
  // =====================================================
  // timing
  localparam int CLK_MHZ      = 100;
  localparam int LOCK_TIME_MS = 5;
  localparam int LOCK_CYCLES  = LOCK_TIME_MS * 1000 * CLK_MHZ;
  localparam int BAND_SLOTS   = 64;
  localparam int DWELL_CYCLES = LOCK_CYCLES / BAND_SLOTS;
  // =====================================================
  // types
  typedef enum logic [1:0] {S_IDLE, S_DWELL, S_LOCKED} search_e;
  typedef struct packed {
    logic       pll_enable;
    logic [5:0] band;
    logic [1:0] drive;
    logic [2:0] bias;
    logic [4:0] loop_bw;
  } pll_cfg_s;
  // divider code to ratio: 1, 2, 4, 8
  function automatic logic [3:0] ratio_of(input logic [1:0] code);
    ratio_of = 4'h1 << code;
  endfunction
endpackage

// >>> core/dac_sample_clock_source.sv
`timescale 1ns/1ps
module dac_sample_clock_source #(
  parameter int DWELL = dac_clk_pkg::DWELL_CYCLES
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // 3-wire serial port
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_csn,
  input  wire logic                  spi_sdio_i,
  output logic                       spi_sdio_o,
  output logic                       spi_sdio_oe,
  // clocks
  input  wire logic                  reference_clock_input,
  input  wire logic                  pll_clock_in,
  output logic                       converter_sample_clock,
  // analog pll side
  input  wire logic                  vco_lock_raw,
  output dac_clk_pkg::pll_cfg_s      pll_cfg,
  output logic [6:0]                 vco_total_ratio,
  output logic [3:0]                 sample_ratio,
  output logic                       pll_lock_pin
);
  import dac_clk_pkg::*;

  // =====================================================
  // input synchronisers
  logic [2:0] sclk_s_q;
  logic [1:0] csn_s_q;
  logic [1:0] sdio_s_q;
  logic [1:0] lock_s_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s_q <= 3'h0;
      csn_s_q  <= 2'h3;
      sdio_s_q <= 2'h0;
      lock_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
      csn_s_q  <= {csn_s_q[0], spi_csn};
      sdio_s_q <= {sdio_s_q[0], spi_sdio_i};
      lock_s_q <= {lock_s_q[0], vco_lock_raw};
    end
  end
  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire csn       = csn_s_q[1];
  wire din       = sdio_s_q[1];
  wire lock_in   = lock_s_q[1];

  // =====================================================
  // serial slave
  logic [4:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] instr_q;
  logic [7:0] rd_shift_q;
  logic       sdio_o_q;
  logic       sdio_oe_q;
  logic [7:0] rd_mux;
  wire        instr_done = sclk_rise & ~csn & (bit_cnt_q == LAST_INSTR_BIT);
  wire [7:0]  instr_word = {shift_q, din};
  wire        is_read    = instr_q[RW_BIT];
  wire [4:0]  wr_addr    = instr_q[4:0];
  wire [7:0]  wr_data    = {shift_q, din};
  wire        wr_en      = sclk_rise & ~csn & ~is_read & (bit_cnt_q == LAST_FRAME_BIT);
  wire        rd_phase   = ~csn & is_read & (bit_cnt_q > LAST_INSTR_BIT);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_q  <= 5'h00;
      shift_q    <= 7'h00;
      instr_q    <= 8'h00;
      rd_shift_q <= 8'h00;
      sdio_o_q   <= 1'b0;
      sdio_oe_q  <= 1'b0;
    end else if (csn) begin
      bit_cnt_q <= 5'h00;
      sdio_oe_q <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shift_q   <= {shift_q[5:0], din};
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (instr_done) begin
        instr_q    <= instr_word;
        rd_shift_q <= rd_mux;
      end
      if (sclk_fall && rd_phase) begin
        sdio_oe_q  <= 1'b1;
        sdio_o_q   <= rd_shift_q[7];
        rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
    end
  end
  assign spi_sdio_o  = sdio_o_q;
  assign spi_sdio_oe = sdio_oe_q;

  // =====================================================
  // configuration registers
  logic [7:0] band_reg_q;
  logic [7:0] ctrl_reg_q;
  logic [4:0] lbw_reg_q;
  wire wr_band = wr_en & (wr_addr == REG_VCO_BAND);
  wire wr_ctrl = wr_en & (wr_addr == REG_PLL_CTRL);
  wire wr_lbw  = wr_en & (wr_addr == REG_LOOP_BW);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      band_reg_q <= RST_VCO_BAND;
      ctrl_reg_q <= RST_PLL_CTRL;
      lbw_reg_q  <= RST_LOOP_BW;
    end else begin
      if (wr_band) band_reg_q <= wr_data;
      if (wr_ctrl) ctrl_reg_q <= wr_data;
      if (wr_lbw)  lbw_reg_q  <= wr_data[LBW_HI:0];
    end
  end
  wire       pll_en     = ctrl_reg_q[PLL_EN_BIT];
  wire [1:0] n1_code    = ctrl_reg_q[N1_HI:N1_LO];
  wire [1:0] n2_code    = ctrl_reg_q[N2_HI:N2_LO];
  wire [5:0] band_field = band_reg_q[BAND_HI:BAND_LO];
  wire       auto_mode  = (band_field == BAND_AUTO);
  wire [3:0] n1_ratio   = ratio_of(n1_code);
  wire [3:0] n2_ratio   = ratio_of(n2_code);
  wire [7:0] vco_prod   = n1_ratio * n2_ratio;

  // =====================================================
  // automatic band search
  search_e    state_q;
  logic [5:0] search_band_q;
  logic [5:0] chosen_band_q;
  logic       auto_done_q;
  logic [31:0] dwell_q;
  wire dwell_end  = (dwell_q == 32'(DWELL - 1));
  wire start_srch = pll_en & auto_mode & (state_q == S_IDLE) & ~auto_done_q;
  wire abort_srch = ~pll_en | wr_band;
  wire [5:0] next_band = (search_band_q == BAND_MAX) ? BAND_MIN : search_band_q + 6'h01;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q       <= S_IDLE;
      search_band_q <= BAND_MIN;
      chosen_band_q <= BAND_MIN;
      auto_done_q   <= 1'b0;
      dwell_q       <= 32'h0;
    end else if (abort_srch) begin
      state_q     <= S_IDLE;
      auto_done_q <= 1'b0;
      dwell_q     <= 32'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start_srch) begin
            state_q       <= S_DWELL;
            search_band_q <= BAND_MIN;
            dwell_q       <= 32'h0;
          end
        end
        S_DWELL: begin
          if (lock_in) begin
            state_q       <= S_LOCKED;
            chosen_band_q <= search_band_q;
            auto_done_q   <= 1'b1;
          end else if (dwell_end) begin
            search_band_q <= next_band;
            dwell_q       <= 32'h0;
          end else begin
            dwell_q <= dwell_q + 32'h1;
          end
        end
        S_LOCKED: state_q <= S_LOCKED;
        default:  state_q <= S_IDLE;
      endcase
    end
  end

  // =====================================================
  // readback and status
  wire [5:0] band_rd = auto_done_q ? chosen_band_q : band_field;
  wire locked = pll_en & lock_in & (~auto_mode | (state_q == S_LOCKED));
  wire [7:0] status_rd = {6'h00, locked, 1'b0} & (8'h01 << LOCK_BIT);
  wire [7:0] band_word = {band_rd, band_reg_q[DRIVE_HI:0]};
  assign rd_mux = (instr_word[4:0] == REG_LOCK_STATUS) ? status_rd :
                  (instr_word[4:0] == REG_VCO_BAND)    ? band_word :
                  (instr_word[4:0] == REG_PLL_CTRL)    ? ctrl_reg_q :
                  (instr_word[4:0] == REG_LOOP_BW)     ? {3'h0, lbw_reg_q} : 8'h00;
  assign pll_lock_pin = locked;

  // =====================================================
  // applied settings and sample clock select
  pll_cfg_s   cfg_q;
  logic [6:0] vco_ratio_q;
  logic [3:0] smp_ratio_q;
  wire [5:0] band_apply = auto_mode ? (auto_done_q ? chosen_band_q : search_band_q)
                                    : band_field;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q       <= '0;
      vco_ratio_q <= 7'h01;
      smp_ratio_q <= 4'h1;
    end else if (pll_en) begin
      cfg_q       <= '{1'b1, band_apply, band_reg_q[DRIVE_HI:0],
                       ctrl_reg_q[BIAS_HI:0], lbw_reg_q};
      vco_ratio_q <= vco_prod[6:0];
      smp_ratio_q <= n2_ratio;
    end else begin
      cfg_q.pll_enable <= 1'b0;
    end
  end
  assign pll_cfg         = cfg_q;
  assign vco_total_ratio = vco_ratio_q;
  assign sample_ratio    = smp_ratio_q;
  assign converter_sample_clock = pll_en ? pll_clock_in : reference_clock_input;

  // =====================================================
  // assertions
  sequence s_dwell_miss;
    (state_q == S_DWELL) && !lock_in && dwell_end && !abort_srch;
  endsequence
  sequence s_stable_ctrl;
    pll_en && !wr_ctrl;
  endsequence

  a_bypass_route: assert property (@(posedge clk) disable iff (!resetn)
    !pll_en |-> converter_sample_clock == reference_clock_input)
    else $error("bypass clock not routed");
  a_pll_route: assert property (@(posedge clk) disable iff (!resetn)
    pll_en |-> converter_sample_clock == pll_clock_in)
    else $error("pll clock not routed");
  a_vco_ratio: assert property (@(posedge clk) disable iff (!resetn)
    s_stable_ctrl ##1 s_stable_ctrl |-> vco_total_ratio == 7'(n1_ratio * n2_ratio))
    else $error("vco ratio wrong");
  a_sample_ratio: assert property (@(posedge clk) disable iff (!resetn)
    s_stable_ctrl ##1 s_stable_ctrl |-> sample_ratio == n2_ratio)
    else $error("sample ratio wrong");
  a_ctrl_fields: assert property (@(posedge clk) disable iff (!resetn)
    wr_ctrl |=> n1_code == $past(wr_data[N1_HI:N1_LO]) && n2_code == $past(wr_data[N2_HI:N2_LO]))
    else $error("divider fields misplaced");
  a_auto_start: assert property (@(posedge clk) disable iff (!resetn)
    start_srch && !abort_srch |=> state_q == S_DWELL && search_band_q == BAND_MIN)
    else $error("auto search did not start");
  a_band_step: assert property (@(posedge clk) disable iff (!resetn)
    s_dwell_miss |=> search_band_q == $past(next_band) && dwell_q == 32'h0)
    else $error("band search did not step");
  a_lock_report: assert property (@(posedge clk) disable iff (!resetn)
    pll_lock_pin |-> status_rd[LOCK_BIT] && pll_en)
    else $error("lock pin and status differ");
  a_band_readback: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == S_LOCKED) |-> band_rd == chosen_band_q)
    else $error("readback not chosen band");
  a_lbw_store: assert property (@(posedge clk) disable iff (!resetn)
    wr_lbw |=> lbw_reg_q == $past(wr_data[LBW_HI:0]))
    else $error("loop bandwidth not stored");
  a_hold_disabled: assert property (@(posedge clk) disable iff (!resetn)
    !pll_en ##1 !pll_en |-> $stable(vco_total_ratio) && $stable(pll_cfg.band))
    else $error("settings changed while pll off");
endmodule

// >>> test/pll_model.sv
`timescale 1ns/1ps
module pll_model (
  // applied settings
  input  wire dac_clk_pkg::pll_cfg_s cfg,
  input  wire logic [5:0]            lock_band,
  // clocks and lock
  output logic                       ref_clk,
  output logic                       pll_clk,
  output logic                       lock_raw
);
  import dac_clk_pkg::*;
  // ==========================================
  // clocks
  initial ref_clk = 1'b0;
  initial pll_clk = 1'b0;
  // 25 MHz reference, far below the multiplier input ceiling
  always #20 ref_clk = ~ref_clk;
  // multiplied clock only runs with the loop enabled
  always #2.5 pll_clk = cfg.pll_enable ? ~pll_clk : pll_clk;
  // ==========================================
  // lock only while tuned to the band that fits this part
  assign lock_raw = cfg.pll_enable && (cfg.band == lock_band);
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dac_clk_pkg::*;
  localparam int DW = 16;
  logic clk, resetn, sclk, csn, host_bit, sdio_i, sdio_o, sdio_oe;
  logic ref_clk, pll_clk, dac_clk, lock_raw, lock_pin;
  logic [6:0] vco_ratio;
  logic [3:0] s_ratio;
  logic [5:0] lock_band;
  pll_cfg_s   cfg;
  logic [7:0] v, sh;
  logic [7:0] exp_q[$];
  int         nb, n, checks, error_cnt, cyc;
  assign sdio_i = sdio_oe ? sdio_o : host_bit;
  dac_sample_clock_source #(.DWELL(DW)) u_dac_sample_clock_source (
    .clk(clk), .resetn(resetn), .spi_sclk(sclk), .spi_csn(csn), .spi_sdio_i(sdio_i),
    .spi_sdio_o(sdio_o), .spi_sdio_oe(sdio_oe), .reference_clock_input(ref_clk),
    .pll_clock_in(pll_clk), .converter_sample_clock(dac_clk), .vco_lock_raw(lock_raw),
    .pll_cfg(cfg), .vco_total_ratio(vco_ratio), .sample_ratio(s_ratio),
    .pll_lock_pin(lock_pin));
  pll_model u_pll_model (.cfg(cfg), .lock_band(lock_band), .ref_clk(ref_clk),
    .pll_clk(pll_clk), .lock_raw(lock_raw));
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] ins, input logic [7:0] dat, input int nbits);
    logic [15:0] w;
    w = {ins, dat};
    @(negedge clk) csn = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      host_bit = w[15-i];
      repeat (5) @(negedge clk);
      sclk = 1'b1;
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (5) @(negedge clk);
    csn = 1'b1;
    host_bit = ~host_bit;
    repeat (8) @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    frame({3'b000, a}, d, 16);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    frame({3'b100, a}, 8'h00, 16);
  endtask
  task automatic mux(input logic pll);
    repeat (7) begin
      #3.3;
      check("sample clock", {7'h00, dac_clk}, {7'h00, pll ? pll_clk : ref_clk});
    end
  endtask
  // ==========================================
  // read data monitor
  always @(posedge sclk) begin
    if (!csn && sdio_oe === 1'b1) begin
      sh = {sh[6:0], sdio_i};
      nb++;
      if (nb == 8) begin
        nb = 0;
        check("read data", sh, exp_q.pop_front());
      end
    end
  end
  // ==========================================
  // clock and hang guard
  always #5 clk = ~clk;
  always @(negedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end
  // ==========================================
  // main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    sclk = 1'b0;
    csn = 1'b1;
    host_bit = 1'b0;
    lock_band = 6'h00;
    void'($urandom(34));
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    check("ratio", {1'b0, vco_ratio}, 8'h01);
    check("pll enable", {7'h00, cfg.pll_enable}, 8'h00);
    rd(5'h08, 8'h03);
    rd(5'h09, 8'h03);
    rd(5'h0a, 8'h0f);
    rd(5'h00, 8'h00);
    rd(5'h15, 8'h00);
    // fields written with the loop off
    wr(5'h08, 8'h57);
    wr(5'h09, 8'h7b);
    check("band", {2'b00, cfg.band}, 8'h00);
    check("ratio", {1'b0, vco_ratio}, 8'h01);
    rd(5'h09, 8'h7b);
    mux(1'b0);
    // every divider pair with the loop on
    for (int c = 0; c < 16; c++) begin
      v = {1'b1, 4'(c), 3'b011};
      wr(5'h09, v);
      check("vco ratio", {1'b0, vco_ratio}, 8'(1 << ((c >> 2) + (c & 3))));
      check("dac ratio", {4'h0, s_ratio}, 8'(1 << (c & 3)));
    end
    rd(5'h09, v);
    check("pll enable", {7'h00, cfg.pll_enable}, 8'h01);
    check("bias", {5'h00, cfg.bias}, 8'h03);
    check("drive", {6'h00, cfg.drive}, 8'h03);
    check("band", {2'b00, cfg.band}, 8'h15);
    mux(1'b1);
    v = 8'($urandom) | 8'he0;
    wr(5'h0a, v);
    rd(5'h0a, v & 8'h1f);
    check("loop bw", {3'b000, cfg.loop_bw}, v & 8'h1f);
    frame(8'h0a, 8'h00, 12);
    rd(5'h0a, v & 8'h1f);
    // automatic search
    lock_band = 6'($urandom_range(2, 20));
    wr(5'h08, 8'hff);
    n = 0;
    while (lock_pin !== 1'b1 && n < 64 * DW) begin
      @(negedge clk);
      n++;
    end
    check("lock pin", {7'h00, lock_pin}, 8'h01);
    rd(5'h00, 8'h02);
    rd(5'h08, {lock_band, 2'b11});
    // offset the found band, then the top manual code
    lock_band = lock_band + 6'h01;
    wr(5'h08, {lock_band, 2'b11});
    check("band", {2'b00, cfg.band}, {2'b00, lock_band});
    check("lock pin", {7'h00, lock_pin}, 8'h01);
    wr(5'h08, 8'hfb);
    check("band", {2'b00, cfg.band}, 8'h3e);
    check("lock pin", {7'h00, lock_pin}, 8'h00);
    wr(5'h09, 8'h03);
    check("pll enable", {7'h00, cfg.pll_enable}, 8'h00);
    check("band", {2'b00, cfg.band}, 8'h3e);
    mux(1'b0);
    close_out;
  end
endmodule
